/* bench/dat_chk.sv */
// Link timing checker for the alert/leveling pair
`timescale 1ns/1ps
module dat_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] cmd,
  input wire logic par_err,
  input wire logic crc_err,
  input wire logic dqs_en,
  input wire logic dqs_rise,
  input wire logic cke,
  input wire logic alert_n
);
  logic [7:0] wl_age, mrs_age, syn_age, ref_age, wr_age, err_age;
  // Saturating age, so a long quiet spell never wraps into a false gap
  function automatic logic [7:0] up(input logic hit, input logic [7:0] a);
    return hit ? 8'h01 : (a == 8'hfe ? a : a + 8'h01);
  endfunction
  // Cycles since each tracked event on the link: leveling, mode, sync, refresh, write and parity/CRC error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wl_age <= 8'hfe;
      mrs_age <= 8'hfe;
      syn_age <= 8'hfe;
      ref_age <= 8'hfe;
      wr_age <= 8'hfe;
      err_age <= 8'hfe;
    end else begin
      wl_age <= up(cmd == dat_pkg::DAT_CMD_WL, wl_age);
      mrs_age <= up(cmd == dat_pkg::DAT_CMD_MRS, mrs_age);
      syn_age <= up(cmd == dat_pkg::DAT_CMD_SYNC, syn_age);
      ref_age <= up(cmd == dat_pkg::DAT_CMD_REF, ref_age);
      wr_age <= up(cmd == dat_pkg::DAT_CMD_WR, wr_age);
      err_age <= up(par_err | crc_err, err_age);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_wl_dqs_en: assert property ($rose(dqs_en) |-> wl_age >= 8'h19)
    else $error("strobe enabled too soon after leveling entry");
  chk_wl_rise: assert property (dqs_rise |-> wl_age >= 8'h28)
    else $error("strobe edge too soon after leveling entry");
  chk_sync_gap: assert property (cmd == dat_pkg::DAT_CMD_SYNC |-> mrs_age >= 8'h1c)
    else $error("sync pulse too close to mode command");
  chk_sync_even: assert property (cmd == dat_pkg::DAT_CMD_SYNC |-> !mrs_age[0])
    else $error("sync gap is odd");
  chk_gear_cmd: assert property ((cmd != dat_pkg::DAT_CMD_DES) && (cmd != dat_pkg::DAT_CMD_SYNC)
    |-> syn_age >= 8'h18)
    else $error("command too soon after sync");
  chk_ref_act: assert property (cmd == dat_pkg::DAT_CMD_ACT |-> ref_age >= dat_pkg::TRFC1_CYC)
    else $error("activate inside refresh time");
  chk_wr_pd: assert property ($fell(cke) |-> wr_age >= 8'h24)
    else $error("power-down too soon after write");
  chk_alert_cause: assert property (!alert_n |-> err_age <= 8'hc0)
    else $error("alert without recent error");
endmodule

/* bench/tb_ddr4_alert_leveling_timing.sv */
// Self-checking bench for the controller/device pair
`timescale 1ns/1ps
module tb_ddr4_alert_leveling_timing;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, g32 = 1'b0, bc4 = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h8ae4;
  logic pready, pslverr, er, ws, pd;
  int mismatches = 0, n_tests = 0, n, d8, d4;
  dat_pkg::dat_cmd_t cl [6] = '{dat_pkg::DAT_CMD_ACT, dat_pkg::DAT_CMD_PRE, dat_pkg::DAT_CMD_REF,
    dat_pkg::DAT_CMD_RD, dat_pkg::DAT_CMD_WR, dat_pkg::DAT_CMD_MRS};
  dat_link_if l1 ();
  dat_link_if l2 ();
  dat_ctrl dat_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(l1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dat_dev dat_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(l1), .grade_3200(g32), .bc4_fixed(bc4),
    .cmd_exec(), .wr_start(), .in_pd(), .busy());
  // Second device faces the bench, which injects the errors
  dat_dev dat_dev_i2 (.clk_sys(clk_sys), .rst_n(rst_n), .link(l2), .grade_3200(g32), .bc4_fixed(bc4),
    .cmd_exec(), .wr_start(ws), .in_pd(pd), .busy());
  dat_chk chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(l1.cmd), .par_err(l1.par_err), .crc_err(l1.crc_err),
    .dqs_en(l1.dqs_en), .dqs_rise(l1.dqs_rise), .cke(l1.cke), .alert_n(l1.alert_n));
  always #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int pw(input logic p, input logic g);
    return !p ? dat_pkg::CRC_PW : (g ? dat_pkg::PAR_PW_3200 : dat_pkg::PAR_PW_2933);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Order a command and wait for it on the link
  task automatic wcmd(input dat_pkg::dat_cmd_t c);
    apb(1'b1, dat_pkg::REG_CMD, {28'h0, c});
    n = 0;
    while (l1.cmd !== c && n < 80) begin @(posedge clk_sys); n++; end
    chk("link cmd", l1.cmd, c);
    repeat (40) @(posedge clk_sys);
  endtask
  // Inject one error on the bench link, measure the alert
  task automatic alert(input logic p);
    @(posedge clk_sys);
    l2.par_err <= p; l2.crc_err <= !p;
    @(posedge clk_sys);
    l2.par_err <= 1'b0; l2.crc_err <= 1'b0;
    n = 0;
    while (l2.alert_n === 1'b1 && n < 20) begin @(posedge clk_sys); n++; end
    chk("alert delay", 32'(n <= (p ? dat_pkg::PAR_ALERT_ON_CYC + 1 : 2)), 32'h1);
    n = 0;
    while (l2.alert_n === 1'b0 && n < 300) begin @(posedge clk_sys); n++; end
    chk("alert width", n, pw(p, g32));
  endtask
  // Write on the bench link; cycles until the internal write starts
  task automatic wrs(output int d);
    @(posedge clk_sys);
    l2.cmd <= dat_pkg::DAT_CMD_WR;
    @(posedge clk_sys);
    l2.cmd <= dat_pkg::DAT_CMD_DES;
    d = 1;
    while (ws !== 1'b1 && d < 60) begin @(posedge clk_sys); d++; end
    repeat (10) @(posedge clk_sys);
  endtask
  initial begin
    l2.cmd = dat_pkg::DAT_CMD_DES; l2.par_err = 1'b0; l2.crc_err = 1'b0;
    l2.dqs_en = 1'b0; l2.dqs_rise = 1'b0; l2.cke = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, dat_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", rd, {24'h0, dat_pkg::CTRL_RESET});
    apb(1'b0, dat_pkg::REG_TIMING, 32'h0);
    chk("timing reset", rd, {8'h0, dat_pkg::MOD_CYC_RESET, dat_pkg::WRCRC_CYC_RESET, dat_pkg::WR_CYC_RESET});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", er, 1'b1);
    // Random mode bits, granularity kept coarse, lock flag set for reads
    seed = xs(seed);
    apb(1'b1, dat_pkg::REG_CTRL, (seed & 32'h8f) | 32'h40);
    apb(1'b0, dat_pkg::REG_CTRL, 32'h0);
    chk("ctrl back", rd & 32'hff, (seed & 32'h8f) | 32'h40);
    $display("test registers done");
    wcmd(dat_pkg::DAT_CMD_WL);
    wcmd(dat_pkg::DAT_CMD_MRS);
    wcmd(dat_pkg::DAT_CMD_SYNC);
    wcmd(dat_pkg::DAT_CMD_REF);
    wcmd(dat_pkg::DAT_CMD_ACT);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wcmd(cl[seed % 6]);
    end
    $display("test commands done");
    for (int g = 0; g < 2; g++) begin
      g32 <= g[0];
      alert(1'b1);
      alert(1'b0);
    end
    $display("test alerts done");
    wrs(d8);
    bc4 <= 1'b1;
    wrs(d4);
    chk("bc4 earlier", 32'(d8 - d4), 32'h2);
    chk("bl8 start", 32'(d8 >= 20 && d8 <= 22), 32'h1);
    @(posedge clk_sys);
    l2.cmd <= dat_pkg::DAT_CMD_REF;
    @(posedge clk_sys);
    l2.cmd <= dat_pkg::DAT_CMD_DES; l2.cke <= 1'b0;
    n = 0;
    while (pd !== 1'b1 && n < 60) begin @(posedge clk_sys); n++; end
    chk("power-down", pd, 1'b1);
    $display("test device done");
    tally_and_finish();
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
endmodule

/* logic/dat_ctrl.sv */
// Controller end: APB registers, sequencing gaps, alert response
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dat_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  dat_link_if.ctrl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {DAT_IDLE = 2'b00, DAT_WAIT = 2'b01, DAT_SEND = 2'b10} dat_st_t;
  dat_st_t st;
  logic [7:0] ctrl;
  logic [23:0] timing;
  logic [3:0] pend_cmd;
  logic [8:0] gap;
  logic [8:0] rfc_cnt;
  logic [7:0] wl_cnt;
  logic alert_seen;
  logic lost;
  logic odd_ph;
  logic [3:0] cmd_q;
  wire acc = psel && penable;
  wire wr_en = acc && pwrite;
  wire hit_ctrl = (paddr == dat_pkg::REG_CTRL);
  wire hit_cmd = (paddr == dat_pkg::REG_CMD);
  wire hit_stat = (paddr == dat_pkg::REG_STATUS);
  wire hit_tim = (paddr == dat_pkg::REG_TIMING);
  wire mapped = hit_ctrl || hit_cmd || hit_stat || hit_tim;
  wire crc_dm = ctrl[dat_pkg::CTRL_CRC] && ctrl[dat_pkg::CTRL_DM];
  wire [7:0] wr_cyc = crc_dm ? timing[dat_pkg::TIM_WRCRC_LO +: 8] : timing[dat_pkg::TIM_WR_LO +: 8];
  wire [7:0] mod_cyc = timing[dat_pkg::TIM_MOD_LO +: 8];
  wire [1:0] gran = ctrl[dat_pkg::CTRL_GRAN_LO +: 2];
  wire [8:0] rfc_sel = (gran == 2'b00) ? 9'(dat_pkg::TRFC1_CYC)
                     : (gran == 2'b01) ? 9'(dat_pkg::TRFC2_CYC) : 9'(dat_pkg::TRFC4_CYC);
  wire [8:0] sync_gap = {1'b0, mod_cyc} + 9'(dat_pkg::SYNC_EXTRA_NCK);
  wire [8:0] even_sync = sync_gap + {8'h00, sync_gap[0]};
  wire [8:0] even_mod = {1'b0, mod_cyc} + {8'h00, mod_cyc[0]};
  wire need_dll = (pend_cmd == dat_pkg::DAT_CMD_RD) || (pend_cmd == dat_pkg::DAT_CMD_RDA)
                  || (pend_cmd == dat_pkg::DAT_CMD_ODT);
  wire blocked = (need_dll && !ctrl[dat_pkg::CTRL_DLL])
                 || (pend_cmd == dat_pkg::DAT_CMD_ACT && rfc_cnt != 9'h000)
                 || (alert_seen && ctrl[dat_pkg::CTRL_PERSIST])
                 || (pend_cmd == dat_pkg::DAT_CMD_SYNC && odd_ph)
                 || (gap != 9'h000);
  wire [31:0] stat_word = {27'h0, st == DAT_IDLE, lost, alert_seen, ~link.alert_n, ctrl[dat_pkg::CTRL_DLL]};
  // APB slave: pready registered a cycle after psel, so no wait state; error on unmapped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !mapped;
      prdata <= hit_ctrl ? {24'h0, ctrl} : hit_tim ? {8'h0, timing} : hit_stat ? stat_word : 32'h0;
    end
  end
  // Config registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= dat_pkg::CTRL_RESET;
      timing <= {dat_pkg::MOD_CYC_RESET, dat_pkg::WRCRC_CYC_RESET, dat_pkg::WR_CYC_RESET};
    end else if (wr_en && pready && hit_ctrl) begin
      ctrl <= pwdata[7:0];
    end else if (wr_en && pready && hit_tim) begin
      timing <= pwdata[23:0];
    end
  end
  // Alert tracking: set wins over software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alert_seen <= 1'b0;
      lost <= 1'b0;
    end else begin
      alert_seen <= !link.alert_n || (alert_seen && !(wr_en && pready && hit_stat && pwdata[2]));
      // Commands inside the parity window may be lost
      lost <= link.par_err || (lost && !(wr_en && pready && hit_stat && pwdata[3]));
    end
  end
  // Command sequencer with spacing counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= DAT_IDLE;
      pend_cmd <= 4'h0;
      cmd_q <= 4'h0;
      gap <= 9'h000;
      rfc_cnt <= 9'h000;
      wl_cnt <= 8'h00;
      odd_ph <= 1'b0;
    end else begin
      cmd_q <= dat_pkg::DAT_CMD_DES;
      // Phase since the last mode command keeps the sync gap even
      odd_ph <= (st == DAT_SEND && pend_cmd == dat_pkg::DAT_CMD_MRS) ? 1'b0 : ~odd_ph;
      if (gap != 9'h000) gap <= gap - 9'h001;
      if (rfc_cnt != 9'h000) rfc_cnt <= rfc_cnt - 9'h001;
      if (wl_cnt != 8'h00) wl_cnt <= wl_cnt - 8'h01;
      case (st)
        DAT_IDLE: begin
          if (wr_en && pready && hit_cmd) begin
            pend_cmd <= pwdata[3:0];
            st <= DAT_WAIT;
          end
        end
        DAT_WAIT: begin
          if (!blocked) st <= DAT_SEND;
        end
        DAT_SEND: begin
          cmd_q <= pend_cmd;
          st <= DAT_IDLE;
          if (pend_cmd == dat_pkg::DAT_CMD_REF) rfc_cnt <= rfc_sel;
          if (pend_cmd == dat_pkg::DAT_CMD_MRS) gap <= even_sync;
          if (pend_cmd == dat_pkg::DAT_CMD_SYNC) gap <= even_mod;
          if (pend_cmd == dat_pkg::DAT_CMD_WR) gap <= 9'(dat_pkg::WR_START_BL8) + {1'b0, wr_cyc};
          // One extra: the command reaches the link a cycle after this
          if (pend_cmd == dat_pkg::DAT_CMD_WL) wl_cnt <= 8'(dat_pkg::WLMRD_NCK) + 8'h01;
        end
        default: st <= DAT_IDLE;
      endcase
    end
  end
  // Strobe enable and rising edge after write-leveling entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.dqs_en <= 1'b0;
      link.dqs_rise <= 1'b0;
      link.cmd <= 4'h0;
      link.par_err <= 1'b0;
      link.crc_err <= 1'b0;
      link.cke <= 1'b0;
    end else begin
      link.cmd <= cmd_q;
      link.par_err <= 1'b0;
      link.crc_err <= 1'b0;
      link.cke <= 1'b1;
      link.dqs_en <= (wl_cnt != 8'h00) && (wl_cnt <= 8'(dat_pkg::WLMRD_NCK - dat_pkg::WLDQSEN_NCK));
      link.dqs_rise <= (wl_cnt == 8'h01);
    end
  end
endmodule

/* logic/dat_dev.sv */
// Device end: alert pulses, parity window, internal write start, power-down
`timescale 1ns/1ps
module dat_dev (
  input wire logic clk_sys,
  input wire logic rst_n,
  dat_link_if.dev link,
  input wire logic grade_3200,
  input wire logic bc4_fixed,
  output logic cmd_exec,
  output logic wr_start,
  output logic in_pd,
  output logic busy
);
  logic [7:0] par_cnt;
  logic [7:0] crc_cnt;
  logic [3:0] win_cnt;
  logic [3:0] par_dly;
  logic [23:0] wr_pipe;
  logic [7:0] busy_cnt;
  logic alert_q;
  wire in_window = (win_cnt != 4'h0);
  wire cmd_valid = (link.cmd != dat_pkg::DAT_CMD_DES);
  wire [7:0] par_pw = grade_3200 ? dat_pkg::PAR_PW_3200_8 : dat_pkg::PAR_PW_2933_8;
  // Five bits: write latency plus start offset exceeds fifteen
  wire [4:0] wr_off = 5'(dat_pkg::WR_CYC_RESET) + (bc4_fixed ? 5'(dat_pkg::WR_START_BC4_FIXED)
                       : 5'(dat_pkg::WR_START_BL8));
  // A whole cycle already exceeds the longest CRC delay, so react at once
  wire crc_hit = link.crc_err && (crc_cnt == 8'h00);
  wire next_alert = (par_cnt != 8'h00) || (crc_cnt != 8'h00) || crc_hit;
  wire op_start = (link.cmd == dat_pkg::DAT_CMD_ACT) || (link.cmd == dat_pkg::DAT_CMD_PRE)
                  || (link.cmd == dat_pkg::DAT_CMD_REF);
  assign link.alert_n = ~alert_q;
  // Parity window drops commands; errors start the alert after PL
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= 4'h0;
      par_dly <= 4'h0;
      par_cnt <= 8'h00;
      cmd_exec <= 1'b0;
    end else begin
      cmd_exec <= cmd_valid && !in_window && !link.par_err;
      if (link.par_err && !in_window) begin
        win_cnt <= dat_pkg::PAR_LAT_4;
        par_dly <= dat_pkg::PAR_LAT_4 - 4'h1;
      end else if (in_window) begin
        win_cnt <= win_cnt - 4'h1;
      end
      if (par_dly == 4'h1) begin
        par_cnt <= par_pw;
      end else if (par_cnt != 8'h00) begin
        par_cnt <= par_cnt - 8'h01;
      end
      if (par_dly != 4'h0) begin
        par_dly <= par_dly - 4'h1;
      end
    end
  end
  // CRC error alert from the sampling edge, fixed width
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crc_cnt <= 8'h00;
      alert_q <= 1'b0;
    end else begin
      alert_q <= next_alert;
      if (crc_hit) begin
        crc_cnt <= dat_pkg::CRC_PW_8 - 8'h01;
      end else if (crc_cnt != 8'h00) begin
        crc_cnt <= crc_cnt - 8'h01;
      end
    end
  end
  // Internal write start: WL plus 4 or 2 cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pipe <= 16'h0000;
      wr_start <= 1'b0;
    end else begin
      wr_pipe <= {wr_pipe[22:0], (link.cmd == dat_pkg::DAT_CMD_WR) && !in_window};
      wr_start <= wr_pipe[wr_off - 5'h02];
    end
  end
  // CKE may drop mid-operation; low-power state waits for completion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 8'h00;
      in_pd <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (op_start && !in_window) begin
        busy_cnt <= 8'(dat_pkg::TRFC1_CYC);
      end else if (busy_cnt != 8'h00) begin
        busy_cnt <= busy_cnt - 8'h01;
      end
      busy <= (busy_cnt != 8'h00);
      in_pd <= !link.cke && (busy_cnt == 8'h00);
    end
  end
endmodule

/* logic/dat_link_if.sv */
// Command/alert link between controller and device
`timescale 1ns/1ps
interface dat_link_if;
  logic [3:0] cmd;
  logic par_err;
  logic crc_err;
  logic dqs_en;
  logic dqs_rise;
  logic cke;
  logic alert_n;
  modport ctrl (output cmd, par_err, crc_err, dqs_en, dqs_rise, cke, input alert_n);
  modport dev (input cmd, par_err, crc_err, dqs_en, dqs_rise, cke, output alert_n);
endinterface

/* logic/dat_pkg.sv */
// Shared constants and types for the alert/leveling timing pair
package dat_pkg;
  localparam int CLK_PERIOD_PS = 40000;
  // Printed figures in their own units
  localparam int WLMRD_NCK = 40;
  localparam int WLDQSEN_NCK = 25;
  localparam int PAR_LAT_NCK = 6;
  localparam int PAR_ALERT_ON_EXTRA_PS = 6000;
  localparam int PAR_PW_MIN_2933 = 88;
  localparam int PAR_PW_MAX_2933 = 176;
  localparam int PAR_PW_MIN_3200 = 96;
  localparam int PAR_PW_MAX_3200 = 192;
  localparam int PAR_RSP_2933 = 78;
  localparam int PAR_RSP_3200 = 85;
  localparam int CRC_ALERT_MIN_PS = 3000;
  localparam int CRC_ALERT_MAX_PS = 13000;
  localparam int CRC_PW_MIN = 6;
  localparam int CRC_PW_MAX = 10;
  localparam int SYNC_EXTRA_NCK = 4;
  localparam int WR_START_BL8 = 4;
  localparam int WR_START_BC4_FIXED = 2;
  localparam int TRFC1_PS = 350000;
  localparam int TRFC2_PS = 260000;
  localparam int TRFC4_PS = 160000;
  // Round-up conversion, never below one cycle
  function automatic int ru_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  // CRC alert delay: least rounds up, longest rounds down
  localparam int CRC_ALERT_MIN_CYC = ru_cycles(CRC_ALERT_MIN_PS);
  localparam int CRC_ALERT_MAX_CYC_RAW = CRC_ALERT_MAX_PS / CLK_PERIOD_PS;
  localparam int CRC_ALERT_MAX_CYC = (CRC_ALERT_MAX_CYC_RAW < 1) ? 1 : CRC_ALERT_MAX_CYC_RAW;
  localparam int PAR_ALERT_ON_CYC = PAR_LAT_NCK + PAR_ALERT_ON_EXTRA_PS / CLK_PERIOD_PS;
  localparam int TRFC1_CYC = ru_cycles(TRFC1_PS);
  localparam int TRFC2_CYC = ru_cycles(TRFC2_PS);
  localparam int TRFC4_CYC = ru_cycles(TRFC4_PS);
  // Chosen pulse widths inside the windows
  localparam int PAR_PW_2933 = PAR_PW_MIN_2933;
  localparam int PAR_PW_3200 = PAR_PW_MIN_3200;
  localparam int CRC_PW = 8;
  localparam logic [7:0] CRC_PW_8 = 8'(CRC_PW);
  localparam logic [7:0] PAR_PW_2933_8 = 8'(PAR_PW_2933);
  localparam logic [7:0] PAR_PW_3200_8 = 8'(PAR_PW_3200);
  localparam logic [3:0] PAR_LAT_4 = 4'(PAR_LAT_NCK);
  // Command encodings on the link
  typedef enum logic [3:0] {
    DAT_CMD_DES = 4'h0, DAT_CMD_MRS = 4'h1, DAT_CMD_ACT = 4'h2, DAT_CMD_RD = 4'h3,
    DAT_CMD_RDA = 4'h4, DAT_CMD_WR = 4'h5, DAT_CMD_REF = 4'h6, DAT_CMD_PRE = 4'h7,
    DAT_CMD_SYNC = 4'h8, DAT_CMD_ODT = 4'h9, DAT_CMD_WL = 4'ha
  } dat_cmd_t;
  // Controller register offsets (APB byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TIMING = 8'h0c;
  // CTRL field positions
  localparam int CTRL_GRADE = 0;
  localparam int CTRL_PERSIST = 1;
  localparam int CTRL_CRC = 2;
  localparam int CTRL_DM = 3;
  localparam int CTRL_GRAN_LO = 4;
  localparam int CTRL_DLL = 6;
  localparam int CTRL_BC4F = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int TIM_WR_LO = 0;
  localparam int TIM_WRCRC_LO = 8;
  localparam int TIM_MOD_LO = 16;
  localparam logic [7:0] WR_CYC_RESET = 8'h10;
  localparam logic [7:0] WRCRC_CYC_RESET = 8'h12;
  localparam logic [7:0] MOD_CYC_RESET = 8'h18;
  localparam logic [7:0] WL_CYC = 8'h0a;
endpackage
